// [design/thrcfg_pkg.sv]
`default_nettype none
package thrcfg_pkg;
  // Register map, six-bit register address space
  localparam int          ADDR_W         = 6;
  localparam int          DATA_W         = 24;
  localparam logic [5:0]  OFS_EDGE_CFG4  = 6'h28;  // Edge-select group 4
  localparam logic [5:0]  OFS_THR_PAIR0  = 6'h29;  // Threshold pair 0/1
  localparam logic [5:0]  OFS_THR_PAIR1  = 6'h2a;  // Threshold pair 2/3
  localparam logic [5:0]  OFS_THR_PAIR2  = 6'h2b;  // Threshold pair 4/5
  localparam logic [5:0]  OFS_THR_PAIR3  = 6'h2c;  // Threshold pair 6/7
  localparam logic [5:0]  OFS_THR_PAIR4  = 6'h2d;  // Threshold pair 8/9
  // Field layout of a threshold-pair register
  localparam int          THR_W          = 10;
  localparam int          THR_LO_POS     = 0;
  localparam int          THR_HI_POS     = 10;
  localparam int          THR_PAIRS      = 5;
  localparam int          THR_COUNT      = 10;
  localparam int          RSVD_POS       = 20;
  // Edge-select field of input 22
  localparam int          EDGE_SEL_POS   = 0;
  localparam int          EDGE_SEL_W     = 6;
  localparam int          LEVELS         = 3;      // Levels A, B, C
  localparam int          SEL_W          = 3;      // Threshold selector width
  // Reset values
  localparam logic [9:0]  THR_RST        = 10'h000;
  localparam logic [5:0]  EDGE_SEL_RST   = 6'h00;
  localparam logic [23:0] RD_ZERO        = 24'h00_0000;
  // Per-level edge mode encoding
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } thrcfg_edge_t;
endpackage
`default_nettype wire

// [design/thrcfg_top.sv]
// Functional notes
// - Bits 1:0 set level A; 00 disables it
// - Mode 01 flags upward crossings only
// - Mode 10 flags downward crossings only
// - Mode 11 flags both crossing directions
// - Bits 3:2 give level B same encoding
// - Bits 5:4 give level C same encoding
// - Pair 0/1 holds threshold 0 in 9:0
// - Threshold 1 sits in bits 19:10
// - Pair 2/3 holds thresholds 2 and 3
// - Pair 4/5 holds thresholds 4 and 5
// - Pair 6/7 holds thresholds 6 and 7
// - Pair 8/9 holds thresholds 8 and 9
// - Selector value n picks threshold n
`timescale 1ns/1ps
`default_nettype none
module thrcfg_top (
  // Clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            nrst,
  // Register access port
  input  wire logic [thrcfg_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic                            reg_wr,
  input  wire logic [thrcfg_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                            reg_rd,
  output logic      [thrcfg_pkg::DATA_W-1:0]   reg_rdata_q,
  output logic                                 reg_rvalid_q,
  // Threshold selectors of input 22 for levels A, B, C
  input  wire logic [thrcfg_pkg::SEL_W-1:0]    sel_level_a,
  input  wire logic [thrcfg_pkg::SEL_W-1:0]    sel_level_b,
  input  wire logic [thrcfg_pkg::SEL_W-1:0]    sel_level_c,
  // Conversion results of switch input 22
  input  wire logic                            sample_valid,
  input  wire logic [thrcfg_pkg::THR_W-1:0]    sample_value,
  // Threshold values to the comparators
  output logic      [thrcfg_pkg::THR_COUNT*thrcfg_pkg::THR_W-1:0] thr_values,
  output logic      [thrcfg_pkg::EDGE_SEL_W-1:0] input22_irq_edge_select,
  // Crossing events of input 22, bit 0 level A
  output logic      [thrcfg_pkg::LEVELS-1:0]   edge_event_q
);
  import thrcfg_pkg::*;

  // Block overview:
  // Ten 10-bit thresholds live in five pair registers.
  // Each pair register keeps its even threshold low.
  // The odd threshold of a pair sits directly above it.
  // Bits 23:20 of a pair hold no storage at all.
  // The edge-select field covers levels A, B and C.
  // Each level owns a two-bit none/rise/fall/both mode.
  // Selectors come in as ports from the mapping logic.
  // Each conversion is judged above or below per level.
  // A change of that judgement is a crossing.
  // Crossings pass only when the level's mode allows.
  // Events are one-cycle pulses from flip-flops.
  // The first sample after reset only seeds the history.

  logic [THR_W-1:0]      thr_q [THR_COUNT];    // Ten threshold values
  logic [EDGE_SEL_W-1:0] edge_sel_q;           // Edge-select field
  logic [SEL_W-1:0]      sel_lvl [LEVELS];     // Selector per level
  logic [LEVELS-1:0]     above_q;              // Last outcome per level
  logic                  have_prev_q;          // A prior sample exists
  logic [LEVELS-1:0]     above_d;              // Outcome of new sample

  assign sel_lvl[0] = sel_level_a;
  assign sel_lvl[1] = sel_level_b;
  assign sel_lvl[2] = sel_level_c;
  assign input22_irq_edge_select = edge_sel_q;

  // Threshold pair registers, one per generate step
  genvar gp;
  generate
    for (gp = 0; gp < THR_PAIRS; gp++) begin : g_pair
      localparam logic [ADDR_W-1:0] OFS = OFS_THR_PAIR0 + ADDR_W'(gp);
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          // Fields clear at reset
          thr_q[2*gp]   <= THR_RST;
          thr_q[2*gp+1] <= THR_RST;
        end else if (reg_wr && reg_addr == OFS) begin
          // Low and high fields, reserved bits dropped
          thr_q[2*gp]   <= reg_wdata[THR_LO_POS +: THR_W];
          thr_q[2*gp+1] <= reg_wdata[THR_HI_POS +: THR_W];
        end
      end
      assign thr_values[2*gp*THR_W +: THR_W]     = thr_q[2*gp];
      assign thr_values[(2*gp+1)*THR_W +: THR_W] = thr_q[2*gp+1];
    end
  endgenerate

  // Edge-select field of input 22
  // Only the low six bits of the word are stored.
  // Upper bits belong to other inputs, kept elsewhere.
  // A new mode governs the sample after the write.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      edge_sel_q <= EDGE_SEL_RST;
    end else if (reg_wr && reg_addr == OFS_EDGE_CFG4) begin
      edge_sel_q <= reg_wdata[EDGE_SEL_POS +: EDGE_SEL_W];
    end
  end

  // Read data, one cycle after the strobe
  // Data holds until the next read strobe.
  // Valid is a one-cycle pulse after each strobe.
  // Unmapped offsets answer zero with valid set.
  // A write in the same cycle is not yet visible.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q  <= RD_ZERO;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= RD_ZERO;  // Unmapped and reserved read zero
        for (int i = 0; i < THR_PAIRS; i++) begin
          if (reg_addr == OFS_THR_PAIR0 + ADDR_W'(i)) begin
            reg_rdata_q <= {4'h0, thr_q[2*i+1], thr_q[2*i]};
          end
        end
        if (reg_addr == OFS_EDGE_CFG4) begin
          reg_rdata_q <= {18'h0_0000, edge_sel_q};
        end
      end
    end
  end

  // Above/below outcome against the selected threshold
  // Strictly greater counts as above.
  // Equal to the threshold counts as below.
  // The threshold used is the stored value now.
  // A write in the same cycle affects the next sample.
  always_comb begin
    for (int l = 0; l < LEVELS; l++) begin
      above_d[l] = sample_value > thr_q[sel_lvl[l]];
    end
  end

  // Outcome memory of the previous conversion
  // Updated only when a conversion arrives.
  // Idle cycles keep the last judgement.
  // History flag blocks a false edge after reset.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      above_q     <= '0;
      have_prev_q <= 1'b0;
    end else if (sample_valid) begin
      above_q     <= above_d;
      have_prev_q <= 1'b1;
    end
  end

  // Crossing events per level, gated by the two-bit mode
  // Rise is below to above between two samples.
  // Fall is above to below between two samples.
  // Mode none keeps the level silent.
  // Each event stands exactly one cycle.
  genvar gl;
  generate
    for (gl = 0; gl < LEVELS; gl++) begin : g_level
      thrcfg_edge_t mode;
      logic         rise;
      logic         fall;
      assign mode = thrcfg_edge_t'(edge_sel_q[2*gl +: 2]);
      // Change of outcome between successive samples
      assign rise = sample_valid && have_prev_q && above_d[gl] && !above_q[gl];
      assign fall = sample_valid && have_prev_q && !above_d[gl] && above_q[gl];
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          edge_event_q[gl] <= 1'b0;
        end else begin
          case (mode)
            EDGE_NONE: edge_event_q[gl] <= 1'b0;
            EDGE_RISE: edge_event_q[gl] <= rise;
            EDGE_FALL: edge_event_q[gl] <= fall;
            EDGE_BOTH: edge_event_q[gl] <= rise || fall;
            default:   edge_event_q[gl] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  rd_reserved_a: assert property (reg_rvalid_q |-> reg_rdata_q[23:20] == 4'h0)
    else $error("reserved bits read nonzero");
  thr0_write_a: assert property (reg_wr && reg_addr == 6'h29 |=> thr_values[9:0] == $past(reg_wdata[9:0]))
    else $error("threshold 0 not written");
  thr1_write_a: assert property (reg_wr && reg_addr == 6'h29 |=> thr_values[19:10] == $past(reg_wdata[19:10]))
    else $error("threshold 1 not written");
  thr23_read_a: assert property (reg_wr && reg_addr == 6'h2a ##1 !reg_wr ##1 reg_rd && reg_addr == 6'h2a && !reg_wr
      |=> reg_rdata_q[19:0] == $past(reg_wdata[19:0], 3))
    else $error("pair 2/3 readback wrong");
  thr45_write_a: assert property (reg_wr && reg_addr == 6'h2b |=> thr_values[59:40] == $past(reg_wdata[19:0]))
    else $error("pair 4/5 not written");
  thr67_write_a: assert property (reg_wr && reg_addr == 6'h2c |=> thr_values[79:60] == $past(reg_wdata[19:0]))
    else $error("pair 6/7 not written");
  thr89_write_a: assert property (reg_wr && reg_addr == 6'h2d |=> thr_values[99:80] == $past(reg_wdata[19:0]))
    else $error("pair 8/9 not written");
  none_silent_a: assert property ($past(edge_sel_q[1:0]) == 2'b00 |-> !edge_event_q[0])
    else $error("level A event while disabled");
  rise_only_a: assert property (edge_event_q[0] && $past(edge_sel_q[1:0]) == 2'b01 |-> above_q[0] && !$past(above_q[0]))
    else $error("level A rise event wrong");
  fall_only_a: assert property (edge_event_q[0] && $past(edge_sel_q[1:0]) == 2'b10 |-> !above_q[0] && $past(above_q[0]))
    else $error("level A fall event wrong");
  both_edge_a: assert property ($past(edge_sel_q[1:0]) == 2'b11 && $past(sample_valid) && $past(have_prev_q)
      |-> edge_event_q[0] == (above_q[0] != $past(above_q[0])))
    else $error("level A both-edge event wrong");
  level_b_a: assert property (edge_event_q[1] |-> ($past(edge_sel_q[3:2]) != 2'b00)
      && (above_q[1] != $past(above_q[1])))
    else $error("level B event wrong");
  level_c_a: assert property (edge_event_q[2] |-> ($past(edge_sel_q[5:4]) != 2'b00)
      && (above_q[2] != $past(above_q[2])))
    else $error("level C event wrong");
  sel_pick_a: assert property (sample_valid |=> above_q[0] == ($past(sample_value) > $past(thr_q[sel_level_a])))
    else $error("level A threshold selection wrong");

  rise_seen_c: cover property (edge_event_q[0] && edge_sel_q[1:0] == 2'b01);
  fall_seen_c: cover property (edge_event_q[1] && edge_sel_q[3:2] == 2'b10);
  both_seen_c: cover property (edge_event_q[2] && edge_sel_q[5:4] == 2'b11);
  readback_c:  cover property (reg_rvalid_q && reg_rdata_q != 24'h00_0000);
  fall_a_c:    cover property (edge_event_q[0] && edge_sel_q[1:0] == 2'b10);

  // Register port behaviour
  // Valid follows every read strobe by one edge.
  rvalid_pulse_a: assert property (reg_rvalid_q == $past(reg_rd))
    else $error("read valid not one edge after strobe");
  // Read data stays put between answers.
  rdata_hold_a: assert property (!reg_rvalid_q |-> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  // Unmapped offsets answer zero.
  unmapped_read_a: assert property (reg_rd && (reg_addr < OFS_EDGE_CFG4 || reg_addr > OFS_THR_PAIR4)
      |=> reg_rdata_q == RD_ZERO)
    else $error("unmapped read not zero");
  // Edge-select write lands in the field.
  edge_write_a: assert property (reg_wr && reg_addr == OFS_EDGE_CFG4
      |=> input22_irq_edge_select == $past(reg_wdata[5:0]))
    else $error("edge-select not written");
  // Thresholds change only on a write.
  thr_hold_a: assert property (!reg_wr |=> thr_values == $past(thr_values))
    else $error("thresholds moved without a write");

  // Crossing behaviour
  // No event before a history sample exists.
  first_sample_a: assert property (!$past(have_prev_q) |-> edge_event_q == 3'b000)
    else $error("event without a previous sample");
  // Level B rising mode reports upward changes only.
  rise_b_a: assert property (edge_event_q[1] && $past(edge_sel_q[3:2]) == 2'b01
      |-> above_q[1] && !$past(above_q[1]))
    else $error("level B rise event wrong");
  // Level B falling mode reports downward changes only.
  fall_b_a: assert property (edge_event_q[1] && $past(edge_sel_q[3:2]) == 2'b10
      |-> !above_q[1] && $past(above_q[1]))
    else $error("level B fall event wrong");
  // Level C rising mode reports upward changes only.
  rise_c_a: assert property (edge_event_q[2] && $past(edge_sel_q[5:4]) == 2'b01
      |-> above_q[2] && !$past(above_q[2]))
    else $error("level C rise event wrong");
  // Level C falling mode reports downward changes only.
  fall_c_a: assert property (edge_event_q[2] && $past(edge_sel_q[5:4]) == 2'b10
      |-> !above_q[2] && $past(above_q[2]))
    else $error("level C fall event wrong");
  // Level B compares against its selected threshold.
  sel_pick_b_a: assert property (sample_valid
      |=> above_q[1] == ($past(sample_value) > $past(thr_q[sel_level_b])))
    else $error("level B threshold selection wrong");
  // Level C compares against its selected threshold.
  sel_pick_c_a: assert property (sample_valid
      |=> above_q[2] == ($past(sample_value) > $past(thr_q[sel_level_c])))
    else $error("level C threshold selection wrong");
  // Level B both mode reports every change.
  both_b_a: assert property ($past(edge_sel_q[3:2]) == 2'b11 && $past(sample_valid) && $past(have_prev_q)
      |-> edge_event_q[1] == (above_q[1] != $past(above_q[1])))
    else $error("level B both-edge event wrong");
  // Level C both mode reports every change.
  both_c_a: assert property ($past(edge_sel_q[5:4]) == 2'b11 && $past(sample_valid) && $past(have_prev_q)
      |-> edge_event_q[2] == (above_q[2] != $past(above_q[2])))
    else $error("level C both-edge event wrong");
  // Idle cycles keep the outcome history.
  history_hold_a: assert property (!sample_valid |=> above_q == $past(above_q))
    else $error("outcome history moved without a sample");
  // Level B and C stay silent in mode none.
  none_b_a: assert property ($past(edge_sel_q[3:2]) == 2'b00 |-> !edge_event_q[1])
    else $error("level B event while disabled");
  none_c_a: assert property ($past(edge_sel_q[5:4]) == 2'b00 |-> !edge_event_q[2])
    else $error("level C event while disabled");

endmodule // thrcfg_top
`default_nettype wire

// [sim/thrcfg_host.sv]
`timescale 1ns/1ps
`default_nettype none
module thrcfg_host (
  // Clock
  input  wire logic        clk_sys,
  // Register port toward the device
  output logic [5:0]       reg_addr,
  output logic             reg_wr,
  output logic [23:0]      reg_wdata,
  output logic             reg_rd,
  input  wire logic [23:0] reg_rdata_q,
  input  wire logic        reg_rvalid_q
);
  // Idle bus before the first access
  initial begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_wdata = 24'h00_0000;
    reg_rd = 1'b0;
  end
  // One-cycle write strobe; released data shows its inverse
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // One-cycle read strobe; answer taken one edge later
  task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    v = reg_rvalid_q;
    d = reg_rdata_q;
  endtask
endmodule // thrcfg_host
`default_nettype wire

// [sim/adc_threshold_and_edge_irq_config_test.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_threshold_and_edge_irq_config_test;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] addr;
  logic wr, rd, rv, sv = 1'b0, ab;
  logic [23:0] wd, rdat, w, d;
  logic [9:0] smp = 10'h000;
  logic [99:0] thrv, ethr;
  logic [5:0] esel, m;
  logic [2:0] ev, eev, sl[3];
  logic [1:0] md;
  logic prev[3], have[3];
  int fail_count = 0, n_checks = 0, seed = 61135, cyc = 0, k, r, l;
  int thr[10];
  always #12.5 clk_sys = ~clk_sys;
  thrcfg_host u_host (.clk_sys(clk_sys), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd),
    .reg_rdata_q(rdat), .reg_rvalid_q(rv));
  thrcfg_top uut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd),
    .reg_rdata_q(rdat), .reg_rvalid_q(rv), .sel_level_a(sl[0]), .sel_level_b(sl[1]), .sel_level_c(sl[2]),
    .sample_valid(sv), .sample_value(smp), .thr_values(thrv), .input22_irq_edge_select(esel),
    .edge_event_q(ev));
  // Generic comparison of register-side values
  task automatic chk(input string nm, input logic [99:0] e, input logic [99:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Comparison of crossing events
  task automatic chk_ev(input logic [2:0] e, input logic [2:0] g);
    chk("edge_event_q", {97'h0, e}, {97'h0, g});
  endtask
  // Read one register and check valid flag and data
  task automatic rd_chk(input logic [5:0] a, input logic [23:0] e);
    u_host.rd(a, d, ab);
    chk("reg_rvalid_q", {99'h0, 1'b1}, {99'h0, ab});
    chk("reg_rdata_q", {76'h0, e}, {76'h0, d});
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      $display("[FAIL] timeout expected done seen running");
      wrap_up();
    end
  end
  initial begin
    foreach (sl[i]) sl[i] = 3'h0;
    foreach (prev[i]) begin prev[i] = 1'b0; have[i] = 1'b0; end
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
    for (k = 'h28; k <= 'h2e; k++) rd_chk(k[5:0], 24'h00_0000);
    $display("test reset values done");
    for (k = 0; k < 5; k++) begin
      w = $random(seed);
      u_host.wr(6'h29 + k[5:0], w);
      thr[2*k] = w[9:0];
      thr[2*k+1] = w[19:10];
      rd_chk(6'h29 + k[5:0], w & 24'h0f_ffff);
      @(negedge clk_sys);
      chk("reg_rdata_q hold", {76'h0, w & 24'h0f_ffff}, {76'h0, rdat});
      chk("reg_rvalid_q low", 100'h0, {99'h0, rv});
    end
    u_host.wr(6'h30, 24'hff_ffff);
    rd_chk(6'h30, 24'h00_0000);
    u_host.wr(6'h28, 24'hff_ffff);
    rd_chk(6'h28, 24'h00_003f);
    for (k = 0; k < 10; k++) ethr[10*k +: 10] = thr[k][9:0];
    chk("thr_values", ethr, thrv);
    $display("test register map done");
    for (r = 0; r < 8; r++) begin
      m = (r < 4) ? {3{r[1:0]}} : $random(seed);
      u_host.wr(6'h28, {18'h0, m});
      chk("edge_select", {94'h0, m}, {94'h0, esel});
      foreach (sl[i]) sl[i] = $random(seed);
      repeat (40) begin
        sv = $random(seed);
        smp = (cyc % 9 == 0) ? thr[sl[0]][9:0] : $random(seed);
        eev = 3'h0;
        for (l = 0; l < 3; l++) if (sv) begin
          ab = smp > thr[sl[l]][9:0];
          md = m[2*l +: 2];
          eev[l] = have[l] && (ab != prev[l]) && md[ab ? 0 : 1];
          prev[l] = ab;
          have[l] = 1'b1;
        end
        @(negedge clk_sys);
        chk_ev(eev, ev);
      end
      sv = 1'b0;
    end
    $display("test edge events done");
    wrap_up();
  end
endmodule // adc_threshold_and_edge_irq_config_test
`default_nettype wire
